// [verilog/clk_rst_params.svh]
// constants of the reset and bus clock mode block: port decodes, field
// positions, reset values and reset stretch length.
// assumes inclusion by bare name from the design modules, the checker and the bench.
`ifndef CLK_RST_PARAMS_SVH
`define CLK_RST_PARAMS_SVH

// i/o port decodes
`define PORT_WARM_CPU      16'h0064
`define PORT_COPROC_RESET  16'h00F1
`define PORT_BUS_MODE_CTRL 16'hFC80
`define WARM_CPU_KEY       8'hFE

// bus mode control register fields
`define MODE_CTRL_RESET    8'h00
`define MODE_FAST_BIT      2
`define MODE_SEL_HI        1
`define MODE_SEL_LO        0

// reset stretch, in processor clock periods
`define RESET_TICKS        16

`endif

// [verilog/clk_rst_pkg.sv]
// types shared by the reset and bus clock mode block.
// assumes the constants header is compiled alongside.
package clk_rst_pkg;

   typedef enum logic [1:0] {
      MODE_NON_TURBO = 2'b00,
      MODE_TURBO_BUS = 2'b01,
      MODE_NORMAL    = 2'b10,
      MODE_ASYNC     = 2'b11
   } bus_mode_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } io_req_t;

   typedef struct packed {
      logic proc;
      logic bus;
   } clk_pair_t;

   typedef enum logic [1:0] {
      CPU_IDLE  = 2'b00,
      CPU_WAIT  = 2'b01,
      CPU_ARM   = 2'b10,
      CPU_READY = 2'b11
   } cpu_state_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_CMD  = 2'b01,
      BUS_WAIT = 2'b10
   } bus_state_t;

endpackage

// [verilog/reset_stretch.sv]
// one reset output: held while hold is high, then kept high for TICKS
// further ticks; a start pulse reloads the full stretch.
// assumes tick is a one-cycle pulse per processor clock period.
`timescale 1ns/1ps
`default_nettype none
`include "clk_rst_params.svh"

module reset_stretch #(
   parameter int unsigned TICKS = `RESET_TICKS
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // control
   input  wire logic hold,
   input  wire logic start,
   input  wire logic tick,
   // reset output
   output logic      active
);

   localparam int unsigned CW = $clog2(TICKS + 1);
   localparam logic [CW-1:0] FULL = CW'(TICKS);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          act_d;

   always_comb begin
      cnt_d = cnt_q;
      if (hold || start) begin
         cnt_d = FULL;
      end else if (tick && (cnt_q != '0)) begin
         cnt_d = cnt_q - CW'(1);
      end
      act_d = (cnt_d != '0);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q  <= FULL;
         active <= 1'b1;
      end else begin
         cnt_q  <= cnt_d;
         active <= act_d;
      end
   end

endmodule

`default_nettype wire

// [verilog/reset_and_bus_clock_mode.sv]
// reset outputs and bus clock mode generation.
// assumes every input is synchronous to CLK and that both oscillator
// inputs are well below half the CLK rate, so each of their edges is seen.
//
// How it works
// R01: all three resets high while supply low
// R02: release all three sixteen processor clocks later
// R03: write FEh to 0064h pulses processor reset
// R04: any write to 00F1h pulses coprocessor reset
// R05: shutdown cycle pulses processor reset sixteen clocks
// R06: clock pair follows the selected bus mode
// R07: control bits 2..0 select bus mode
// R08: mode 0 after power-up and system reset
// R09: mode changes switch clocks without runt pulses
// R10: speed toggle rising edge inverts bit 2
// R11: speed toggle leaves bits 1..0 alone
// R12: processor tracker on processor clock, drives ready (code takes start and done on any CLK cycle)
// R13: bus logic on bus clock, async in mode 3
// R14: processor needs two clocks per T-state
// R15: speed toggle synchronised, one action per edge
// R16: pattern 100 behaves as mode 0
`timescale 1ns/1ps
`default_nettype none
`include "clk_rst_params.svh"

module reset_and_bus_clock_mode #(
   parameter int unsigned RESET_TICKS = `RESET_TICKS
) (
   // clock and reset
   input  wire logic                CLK,
   input  wire logic                RESET_N,
   // power and processor status
   input  wire logic                SUPPLY_GOOD_IN,
   input  wire logic                SHUTDOWN_CYCLE_IN,
   // i/o port access
   input  wire clk_rst_pkg::io_req_t IO_REQ,
   output logic [7:0]               IO_RDATA,
   // oscillators and speed switch
   input  wire logic                MAIN_OSC_IN,
   input  wire logic                BUS_OSC_IN,
   input  wire logic                SPEED_TOGGLE_IN,
   // reset outputs
   output logic                     SYSTEM_RESET_OUT,
   output logic                     PROCESSOR_RESET_OUT,
   output logic                     COPROC_RESET_OUT,
   // generated clocks and mode
   output logic                     PROCESSOR_CLOCK_OUT,
   output logic                     EXPANSION_CLOCK_OUT,
   output logic [1:0]               BUS_MODE_OUT,
   // processor cycle tracking
   input  wire logic                CYCLE_START_IN,
   input  wire logic                EARLY_FINISH_N_IN,
   input  wire logic                SLOT_READY_IN,
   output logic                     READY_N_OUT
);

   // mode decode; the undefined pattern falls back to the slow mode
   function automatic clk_rst_pkg::bus_mode_t decode_mode(
      input logic [2:0] sel
   );
      clk_rst_pkg::bus_mode_t m;
      case (sel)
         3'b101:  m = clk_rst_pkg::MODE_TURBO_BUS;   // see R07
         3'b110:  m = clk_rst_pkg::MODE_NORMAL;      // see R07
         3'b111:  m = clk_rst_pkg::MODE_ASYNC;       // see R07
         default: m = clk_rst_pkg::MODE_NON_TURBO;   // see R07 see R16
      endcase
      return m;
   endfunction

   function automatic clk_rst_pkg::clk_pair_t clocks_for(
      input clk_rst_pkg::bus_mode_t m,
      input logic                   main,
      input logic [1:0]             div,
      input logic                   bdiv
   );
      clk_rst_pkg::clk_pair_t p;
      p = '0;
      case (m)
         clk_rst_pkg::MODE_NON_TURBO: begin
            p.proc = div[0];
            p.bus  = div[1];
         end
         clk_rst_pkg::MODE_TURBO_BUS: begin
            p.proc = main;
            p.bus  = div[0];
         end
         clk_rst_pkg::MODE_NORMAL: begin
            p.proc = main;
            p.bus  = div[1];
         end
         clk_rst_pkg::MODE_ASYNC: begin
            p.proc = main;
            p.bus  = bdiv;
         end
         default: begin
            p = '0;
         end
      endcase
      return p;
   endfunction

   // oscillator sampling and dividers
   logic                   main_q;
   logic                   bosc_q;
   logic [1:0]             div_q;
   logic [1:0]             div_d;
   logic                   bdiv_q;
   logic                   bdiv_d;
   clk_rst_pkg::bus_mode_t mode_q;
   clk_rst_pkg::bus_mode_t mode_d;
   clk_rst_pkg::bus_mode_t want;
   clk_rst_pkg::clk_pair_t clk_q;
   clk_rst_pkg::clk_pair_t clk_d;
   clk_rst_pkg::clk_pair_t cand;
   logic                   proc_tick;
   logic                   bus_tick;

   // control register and speed switch
   logic [7:0]             ctrl_q;
   logic [7:0]             ctrl_d;
   logic                   spd_s1_q;
   logic                   spd_s2_q;
   logic                   spd_s3_q;
   logic                   spd_rise;
   logic [7:0]             rdata_d;

   // reset stretchers
   logic                   sys_hold;
   logic                   warm_cpu;
   logic                   warm_cop;

   always_comb begin
      div_d  = div_q;
      bdiv_d = bdiv_q;
      if (MAIN_OSC_IN && !main_q) begin
         div_d = div_q + 2'd1;
      end
      if (BUS_OSC_IN && !bosc_q) begin
         bdiv_d = !bdiv_q;
      end
      want = decode_mode(ctrl_q[2:0]);
      cand = clocks_for(want, MAIN_OSC_IN, div_d, bdiv_d);      // see R06
      mode_d = mode_q;
      // only hand over while old and new clocks are both low, so no
      // high phase is ever cut short
      if ((want != mode_q) && !clk_q.proc && !clk_q.bus &&
          !cand.proc && !cand.bus) begin
         mode_d = want;                                        // see R09
      end
      clk_d     = clocks_for(mode_d, MAIN_OSC_IN, div_d, bdiv_d); // see R06
      proc_tick = clk_d.proc && !clk_q.proc;
      bus_tick  = clk_d.bus && !clk_q.bus;
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         main_q <= 1'b0;
         bosc_q <= 1'b0;
         div_q  <= 2'b00;
         bdiv_q <= 1'b0;
         mode_q <= clk_rst_pkg::MODE_NON_TURBO;
         clk_q  <= '0;
      end else begin
         main_q <= MAIN_OSC_IN;
         bosc_q <= BUS_OSC_IN;
         div_q  <= div_d;
         bdiv_q <= bdiv_d;
         mode_q <= mode_d;
         clk_q  <= clk_d;
      end
   end

   assign PROCESSOR_CLOCK_OUT = clk_q.proc;
   assign EXPANSION_CLOCK_OUT = clk_q.bus;
   assign BUS_MODE_OUT        = mode_q;

   // control register, speed switch and port decodes
   assign spd_rise = spd_s2_q && !spd_s3_q;                     // see R15
   assign warm_cpu = IO_REQ.wr && (IO_REQ.addr == `PORT_WARM_CPU) &&
                     (IO_REQ.wdata == `WARM_CPU_KEY);           // see R03
   assign warm_cop = IO_REQ.wr &&
                     (IO_REQ.addr == `PORT_COPROC_RESET);       // see R04

   always_comb begin
      ctrl_d = ctrl_q;
      if (IO_REQ.wr && (IO_REQ.addr == `PORT_BUS_MODE_CTRL)) begin
         ctrl_d = IO_REQ.wdata;                                 // see R07
      end
      // a toggle in the same cycle as a write acts on the written value
      if (spd_rise) begin
         ctrl_d[`MODE_FAST_BIT] = !ctrl_d[`MODE_FAST_BIT];      // see R10 see R11
      end
      if (SYSTEM_RESET_OUT) begin
         ctrl_d = `MODE_CTRL_RESET;                             // see R08
      end
      rdata_d = 8'h00;
      if (IO_REQ.rd && (IO_REQ.addr == `PORT_BUS_MODE_CTRL)) begin
         rdata_d = ctrl_q;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ctrl_q   <= `MODE_CTRL_RESET;                          // see R08
         spd_s1_q <= 1'b0;
         spd_s2_q <= 1'b0;
         spd_s3_q <= 1'b0;
         IO_RDATA <= 8'h00;
      end else begin
         ctrl_q   <= ctrl_d;
         spd_s1_q <= SPEED_TOGGLE_IN;
         spd_s2_q <= spd_s1_q;
         spd_s3_q <= spd_s2_q;
         IO_RDATA <= rdata_d;
      end
   end

   // all three share the supply hold, so they release on the same tick
   assign sys_hold = !SUPPLY_GOOD_IN;                          // see R01

   reset_stretch #(
      .TICKS (RESET_TICKS)
   ) u_sys_reset (
      .clk    (CLK),
      .rst_n  (RESET_N),
      .hold   (sys_hold),
      .start  (1'b0),
      .tick   (proc_tick),
      .active (SYSTEM_RESET_OUT)
   );                                                          // see R02

   reset_stretch #(
      .TICKS (RESET_TICKS)
   ) u_cpu_reset (
      .clk    (CLK),
      .rst_n  (RESET_N),
      .hold   (sys_hold),
      .start  (warm_cpu || SHUTDOWN_CYCLE_IN),                  // see R03 see R05
      .tick   (proc_tick),
      .active (PROCESSOR_RESET_OUT)
   );                                                          // see R02

   reset_stretch #(
      .TICKS (RESET_TICKS)
   ) u_cop_reset (
      .clk    (CLK),
      .rst_n  (RESET_N),
      .hold   (sys_hold),
      .start  (warm_cop),                                      // see R04
      .tick   (proc_tick),
      .active (COPROC_RESET_OUT)
   );                                                          // see R02

   // processor side tracker; T-state phase and ready advanced on processor clock ticks, start and done taken on any CLK cycle
   clk_rst_pkg::cpu_state_t cpu_q;
   clk_rst_pkg::cpu_state_t cpu_d;
   clk_rst_pkg::bus_state_t bus_q;
   clk_rst_pkg::bus_state_t bus_d;
   logic                    tph_q;
   logic                    tph_d;
   logic                    req_tgl_q;
   logic                    req_tgl_d;
   logic                    req_seen_q;
   logic                    req_seen_d;
   logic                    done_tgl_q;
   logic                    done_tgl_d;
   logic                    done_seen_q;
   logic                    done_seen_d;
   logic                    req_s1_q;
   logic                    req_s2_q;
   logic                    done_s1_q;
   logic                    done_s2_q;
   logic                    req_view;
   logic                    done_view;
   logic                    ready_n_d;
   logic                    async_mode;
   logic                    t_end;

   // handshake crosses through two flops only when the bus clock is not
   // derived from the main oscillator; a mode change in mid-cycle is
   // not supported
   assign async_mode = (mode_q == clk_rst_pkg::MODE_ASYNC);
   assign req_view   = async_mode ? req_s2_q : req_tgl_q;       // see R13
   assign done_view  = async_mode ? done_s2_q : done_tgl_q;     // see R13
   assign t_end      = proc_tick && tph_q;                      // see R14

   always_comb begin
      cpu_d       = cpu_q;
      tph_d       = tph_q;
      req_tgl_d   = req_tgl_q;
      done_seen_d = done_seen_q;
      ready_n_d   = READY_N_OUT;
      if (proc_tick) begin
         tph_d = !tph_q;                                       // see R14
      end
      case (cpu_q)
         clk_rst_pkg::CPU_IDLE: begin
            if (CYCLE_START_IN && !PROCESSOR_RESET_OUT) begin
               req_tgl_d = !req_tgl_q;
               cpu_d     = clk_rst_pkg::CPU_WAIT;
            end
         end
         clk_rst_pkg::CPU_WAIT: begin
            if (done_view != done_seen_q) begin
               done_seen_d = done_view;
               cpu_d       = clk_rst_pkg::CPU_ARM;
            end
         end
         clk_rst_pkg::CPU_ARM: begin
            if (t_end) begin
               ready_n_d = 1'b0;                               // see R12
               cpu_d     = clk_rst_pkg::CPU_READY;
            end
         end
         clk_rst_pkg::CPU_READY: begin
            if (t_end) begin
               ready_n_d = 1'b1;
               cpu_d     = clk_rst_pkg::CPU_IDLE;
            end
         end
         default: begin
            cpu_d = clk_rst_pkg::CPU_IDLE;
         end
      endcase
      if (PROCESSOR_RESET_OUT) begin
         cpu_d     = clk_rst_pkg::CPU_IDLE;
         ready_n_d = 1'b1;
      end
   end

   // expansion side, advanced on expansion clock ticks
   always_comb begin
      bus_d      = bus_q;
      req_seen_d = req_seen_q;
      done_tgl_d = done_tgl_q;
      if (bus_tick) begin                                      // see R13
         case (bus_q)
            clk_rst_pkg::BUS_IDLE: begin
               if (req_view != req_seen_q) begin
                  req_seen_d = req_view;
                  bus_d      = clk_rst_pkg::BUS_CMD;
               end
            end
            clk_rst_pkg::BUS_CMD: begin
               bus_d = clk_rst_pkg::BUS_WAIT;
            end
            clk_rst_pkg::BUS_WAIT: begin
               // early finish overrides a slot still holding off
               if (!EARLY_FINISH_N_IN || SLOT_READY_IN) begin
                  done_tgl_d = !done_tgl_q;
                  bus_d      = clk_rst_pkg::BUS_IDLE;
               end
            end
            default: begin
               bus_d = clk_rst_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         cpu_q       <= clk_rst_pkg::CPU_IDLE;
         bus_q       <= clk_rst_pkg::BUS_IDLE;
         tph_q       <= 1'b0;
         req_tgl_q   <= 1'b0;
         req_seen_q  <= 1'b0;
         done_tgl_q  <= 1'b0;
         done_seen_q <= 1'b0;
         req_s1_q    <= 1'b0;
         req_s2_q    <= 1'b0;
         done_s1_q   <= 1'b0;
         done_s2_q   <= 1'b0;
         READY_N_OUT <= 1'b1;
      end else begin
         cpu_q       <= cpu_d;
         bus_q       <= bus_d;
         tph_q       <= tph_d;
         req_tgl_q   <= req_tgl_d;
         req_seen_q  <= req_seen_d;
         done_tgl_q  <= done_tgl_d;
         done_seen_q <= done_seen_d;
         req_s1_q    <= req_tgl_q;
         req_s2_q    <= req_s1_q;
         done_s1_q   <= done_tgl_q;
         done_s2_q   <= done_s1_q;
         READY_N_OUT <= ready_n_d;
      end
   end

endmodule

`default_nettype wire

// [verification/reset_and_bus_clock_mode_monitor.sv]
// checker for the reset and bus clock mode block: reset timing, read data
// idle level and phase lengths of the generated clocks.
// assumes oscillator half periods of 3 (main) and 4 (bus) CLK cycles.
`timescale 1ns/1ps
`default_nettype none
`include "clk_rst_params.svh"

module reset_and_bus_clock_mode_monitor #(
   parameter int unsigned RESET_TICKS = `RESET_TICKS
) (
   // clock and reset
   input wire logic                 CLK,
   input wire logic                 RESET_N,
   // block inputs
   input wire logic                 SUPPLY_GOOD_IN,
   input wire logic                 SHUTDOWN_CYCLE_IN,
   input wire clk_rst_pkg::io_req_t IO_REQ,
   // block outputs
   input wire logic [7:0]           IO_RDATA,
   input wire logic                 SYSTEM_RESET_OUT,
   input wire logic                 PROCESSOR_RESET_OUT,
   input wire logic                 COPROC_RESET_OUT,
   input wire logic                 PROCESSOR_CLOCK_OUT,
   input wire logic                 EXPANSION_CLOCK_OUT,
   input wire logic [1:0]           BUS_MODE_OUT
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   logic       pclk_q;
   logic       rise;
   logic [7:0] sys_n_q, cpu_n_q, cop_n_q;
   logic [7:0] sys_n_d, cpu_n_d, cop_n_d;

   // processor clock rises seen since supply good for system reset, and while the reset stands for the other two; output lag of
   // one or two cycles is why the lower bounds below allow two short
   always_comb begin
      rise    = PROCESSOR_CLOCK_OUT & ~pclk_q;
      sys_n_d = (SUPPLY_GOOD_IN && RESET_N) ? sys_n_q + 8'(rise) : 8'h00;
      cpu_n_d = (PROCESSOR_RESET_OUT && RESET_N) ? cpu_n_q + 8'(rise) : 8'h00;
      cop_n_d = (COPROC_RESET_OUT && RESET_N) ? cop_n_q + 8'(rise) : 8'h00;
   end
   always_ff @(posedge CLK) begin
      pclk_q  <= RESET_N & PROCESSOR_CLOCK_OUT;
      sys_n_q <= sys_n_d;
      cpu_n_q <= cpu_n_d;
      cop_n_q <= cop_n_d;
   end

   supply_low_a:
   assert property (!SUPPLY_GOOD_IN |=> SYSTEM_RESET_OUT &&
      PROCESSOR_RESET_OUT && COPROC_RESET_OUT)
      else $error("resets not held while supply low");
   sys_release_a:
   assert property ($fell(SYSTEM_RESET_OUT) |-> !PROCESSOR_RESET_OUT &&
      !COPROC_RESET_OUT && sys_n_q >= RESET_TICKS - 2 && sys_n_q <= RESET_TICKS)
      else $error("system reset released at wrong time");
   warm_cpu_a:
   assert property ((IO_REQ.wr && IO_REQ.addr == `PORT_WARM_CPU &&
      SUPPLY_GOOD_IN && !SYSTEM_RESET_OUT && !PROCESSOR_RESET_OUT &&
      !SHUTDOWN_CYCLE_IN) |=> !SYSTEM_RESET_OUT && PROCESSOR_RESET_OUT ==
      ($past(IO_REQ.wdata) == `WARM_CPU_KEY))
      else $error("warm write gave wrong processor reset");
   cpu_stretch_a:
   assert property ($fell(PROCESSOR_RESET_OUT) |-> cpu_n_q >= RESET_TICKS - 2)
      else $error("processor reset too short");
   coproc_pulse_a:
   assert property ((IO_REQ.wr && IO_REQ.addr == `PORT_COPROC_RESET &&
      SUPPLY_GOOD_IN && !SYSTEM_RESET_OUT) |=>
      COPROC_RESET_OUT && !SYSTEM_RESET_OUT)
      else $error("coprocessor write gave no coprocessor reset");
   cop_stretch_a:
   assert property ($fell(COPROC_RESET_OUT) |-> cop_n_q >= RESET_TICKS - 2)
      else $error("coprocessor reset too short");
   shutdown_a:
   assert property (SHUTDOWN_CYCLE_IN |=> PROCESSOR_RESET_OUT)
      else $error("shutdown gave no processor reset");
   mode_default_a:
   assert property ($fell(SYSTEM_RESET_OUT) |-> BUS_MODE_OUT == 2'b00)
      else $error("mode not zero after system reset");
   rdata_idle_a:
   assert property (!(IO_REQ.rd && IO_REQ.addr == `PORT_BUS_MODE_CTRL) |=>
      IO_RDATA == 8'h00)
      else $error("read data not zero without control read");
   clk_fast_a:
   assert property (($rose(PROCESSOR_CLOCK_OUT) && BUS_MODE_OUT != 2'b00 &&
      BUS_MODE_OUT == $past(BUS_MODE_OUT, 2)) |->
      PROCESSOR_CLOCK_OUT [*3] ##1 !PROCESSOR_CLOCK_OUT)
      else $error("fast processor clock high phase wrong");
   clk_slow_a:
   assert property (($rose(PROCESSOR_CLOCK_OUT) && BUS_MODE_OUT == 2'b00 &&
      BUS_MODE_OUT == $past(BUS_MODE_OUT, 2)) |->
      PROCESSOR_CLOCK_OUT [*6] ##1 !PROCESSOR_CLOCK_OUT)
      else $error("slow processor clock high phase wrong");
   bus_async_a:
   assert property (($rose(EXPANSION_CLOCK_OUT) && BUS_MODE_OUT == 2'b11 &&
      BUS_MODE_OUT == $past(BUS_MODE_OUT, 2)) |->
      EXPANSION_CLOCK_OUT [*8] ##1 !EXPANSION_CLOCK_OUT)
      else $error("async bus clock high phase wrong");
   bus_turbo_a:
   assert property (($rose(EXPANSION_CLOCK_OUT) && BUS_MODE_OUT == 2'b01) |->
      EXPANSION_CLOCK_OUT [*6] ##1 !EXPANSION_CLOCK_OUT)
      else $error("turbo bus clock high phase wrong");
   proc_runt_a:
   assert property ($rose(PROCESSOR_CLOCK_OUT) |-> PROCESSOR_CLOCK_OUT [*3])
      else $error("processor clock runt pulse");
endmodule

bind reset_and_bus_clock_mode reset_and_bus_clock_mode_monitor #(
   .RESET_TICKS(RESET_TICKS)
) u_reset_and_bus_clock_mode_monitor (.CLK, .RESET_N, .SUPPLY_GOOD_IN,
   .SHUTDOWN_CYCLE_IN, .IO_REQ, .IO_RDATA, .SYSTEM_RESET_OUT,
   .PROCESSOR_RESET_OUT, .COPROC_RESET_OUT, .PROCESSOR_CLOCK_OUT,
   .EXPANSION_CLOCK_OUT, .BUS_MODE_OUT);
`default_nettype wire

// [verification/far_side_model.sv]
// far side model: oscillators, power supply good line and expansion slot.
// assumes clk is the bench clock; every output moves on its falling edge.
`timescale 1ns/1ps
`default_nettype none

module far_side_model (
   // bench clock and controls
   input  wire logic clk,
   input  wire logic power_on,
   input  wire logic slot_stall,
   input  wire logic fast_end,
   // lines into the block
   output logic      main_osc,
   output logic      bus_osc,
   output logic      supply_good,
   output logic      slot_ready,
   output logic      early_finish_n
);
   int main_n = 0;
   int bus_n = 0;

   // both oscillators stay under half the system clock rate, unrelated
   always @(negedge clk) begin
      main_n = (main_n + 1) % 3;
      bus_n = (bus_n + 1) % 4;
      if (main_n == 0) main_osc <= ~main_osc;
      if (bus_n == 0) bus_osc <= ~bus_osc;
      supply_good <= power_on;
      slot_ready <= ~slot_stall;
      early_finish_n <= ~fast_end;
   end
   initial begin
      main_osc = 1'b0;
      bus_osc = 1'b0;
      supply_good = 1'b0;
      slot_ready = 1'b1;
      early_finish_n = 1'b1;
   end
endmodule
`default_nettype wire

// [verification/reset_and_bus_clock_mode_bench.sv]
// bench of the reset and bus clock mode block with a control register model.
// assumes the far side model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
`include "clk_rst_params.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
   n_errors++; $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

module reset_and_bus_clock_mode_bench;
   logic                 clk = 1'b0;
   logic                 reset_n = 1'b0;
   logic                 shutdown = 1'b0, speed = 1'b0, cyc_start = 1'b0;
   logic                 power_on = 1'b0, slot_stall = 1'b0, fast_end = 1'b0;
   clk_rst_pkg::io_req_t io_req = '0;
   logic                 main_osc, bus_osc, supply_good, slot_ready, early_n;
   logic [7:0]           io_rdata;
   logic                 sys_rst, cpu_rst, cop_rst, pclk, eclk, ready_n;
   logic [1:0]           mode;
   int                   n_errors = 0, num_checks = 0, cycles = 0;
   int                   ctrl_m, per, lo;

   always #12.5 clk = ~clk;

   far_side_model u_far_side_model (.clk(clk), .power_on(power_on),
      .slot_stall(slot_stall), .fast_end(fast_end), .main_osc(main_osc),
      .bus_osc(bus_osc), .supply_good(supply_good), .slot_ready(slot_ready),
      .early_finish_n(early_n));

   reset_and_bus_clock_mode u_reset_and_bus_clock_mode (.CLK(clk),
      .RESET_N(reset_n), .SUPPLY_GOOD_IN(supply_good),
      .SHUTDOWN_CYCLE_IN(shutdown), .IO_REQ(io_req), .IO_RDATA(io_rdata),
      .MAIN_OSC_IN(main_osc), .BUS_OSC_IN(bus_osc), .SPEED_TOGGLE_IN(speed),
      .SYSTEM_RESET_OUT(sys_rst), .PROCESSOR_RESET_OUT(cpu_rst),
      .COPROC_RESET_OUT(cop_rst), .PROCESSOR_CLOCK_OUT(pclk),
      .EXPANSION_CLOCK_OUT(eclk), .BUS_MODE_OUT(mode),
      .CYCLE_START_IN(cyc_start), .EARLY_FINISH_N_IN(early_n),
      .SLOT_READY_IN(slot_ready), .READY_N_OUT(ready_n));

   function automatic logic [1:0] mode_of(int c);
      return c[2] ? c[1:0] : 2'b00;
   endfunction

   task automatic wait_cyc(int n);
      repeat (n) @(negedge clk);
   endtask

   // one strobe cycle; read data is looked at in the cycle after the take
   task automatic io(logic wr, logic [15:0] a, logic [7:0] d);
      @(negedge clk);
      io_req = '{wr: wr, rd: !wr, addr: a, wdata: d};
      @(negedge clk);
      io_req = '0;
   endtask

   task automatic rd(logic [15:0] a, logic [7:0] e);
      io(1'b0, a, 8'h00);
      `CHK("read data", e, io_rdata)
   endtask

   task automatic await(ref logic s, input logic v);
      int k = 0;
      while (s !== v && k < 3000) begin
         @(negedge clk);
         k++;
      end
      `CHK("awaited level", v, s)
   endtask

   task automatic set_ctrl(int v);
      ctrl_m = v;
      io(1'b1, `PORT_BUS_MODE_CTRL, ctrl_m[7:0]);
      wait_cyc(60);
   endtask

   task give_verdict;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         give_verdict();
      end
   end

   initial begin
      void'($urandom(13921));
      wait_cyc(3);
      reset_n = 1'b1;
      wait_cyc(20);
      `CHK("all resets", 3'b111, {sys_rst, cpu_rst, cop_rst})
      power_on = 1'b1;
      await(sys_rst, 1'b0);
      `CHK("cpu and cop reset", 2'b00, {cpu_rst, cop_rst})
      `CHK("mode", 2'b00, mode)
      rd(`PORT_BUS_MODE_CTRL, 8'h00);
      for (int p = 0; p < 8; p++) begin
         ctrl_m = ($urandom % 32) * 8 + p;
         io(1'b1, `PORT_BUS_MODE_CTRL, ctrl_m[7:0]);
         rd(`PORT_BUS_MODE_CTRL, ctrl_m[7:0]);
         wait_cyc(60);
         `CHK("mode", mode_of(ctrl_m), mode)
      end
      io(1'b1, 16'hFC81, 8'h05);
      rd(16'h0065, 8'h00);
      rd(`PORT_BUS_MODE_CTRL, ctrl_m[7:0]);
      // level held long so a level-sensitive toggle would flip many times
      set_ctrl(6);
      for (int t = 0; t < 2; t++) begin
         speed = 1'b1;
         wait_cyc(8);
         speed = 1'b0;
         wait_cyc(60);
         ctrl_m = ctrl_m ^ 4;
         rd(`PORT_BUS_MODE_CTRL, ctrl_m[7:0]);
         `CHK("mode", mode_of(ctrl_m), mode)
      end
      per = (mode_of(ctrl_m) == 2'b00) ? 12 : 6;
      for (int k = 0; k < 4; k++) begin
         if (k == 2) begin
            shutdown = 1'b1;
            @(negedge clk);
            shutdown = 1'b0;
         end else if (k == 1)
            io(1'b1, `PORT_COPROC_RESET, 8'($urandom));
         else
            io(1'b1, `PORT_WARM_CPU, (k == 0) ? `WARM_CPU_KEY : 8'hFD);
         `CHK("cpu reset", (k == 0 || k == 2), cpu_rst)
         `CHK("cop reset", (k == 1), cop_rst)
         `CHK("sys reset", 1'b0, sys_rst)
         wait_cyc(per * 16 - 8);
         `CHK("still held", (k == 0 || k == 2), cpu_rst)
         `CHK("still held", (k == 1), cop_rst)
         await(cpu_rst, 1'b0);
         await(cop_rst, 1'b0);
      end
      // ready lasts one processor T-state, two processor clock periods
      for (int m = 0; m < 2; m++) begin
         set_ctrl(m == 0 ? 7 : 0);
         per = (m == 0) ? 6 : 12;
         slot_stall = 1'b1;
         cyc_start = 1'b1;
         @(negedge clk);
         cyc_start = 1'b0;
         wait_cyc(150);
         `CHK("ready while stalled", 1'b1, ready_n)
         // first pass: early finish has to end the cycle while the slot still stalls; second pass: slot ready ends it
         fast_end = (m == 0);
         slot_stall = (m == 0);
         await(ready_n, 1'b0);
         fast_end = 1'b0;
         slot_stall = 1'b0;
         lo = 0;
         while (ready_n === 1'b0 && lo < 100) begin
            @(negedge clk);
            lo++;
         end
         `CHK("ready length", 2 * per, lo)
      end
      set_ctrl(6);
      power_on = 1'b0;
      wait_cyc(4);
      `CHK("all resets", 3'b111, {sys_rst, cpu_rst, cop_rst})
      power_on = 1'b1;
      await(sys_rst, 1'b0);
      `CHK("mode", 2'b00, mode)
      rd(`PORT_BUS_MODE_CTRL, 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
